/* dbp_pkg.sv */
// Constants, field positions and state encoding for the debug serial port
package dbp_pkg;

   // Instruction timing in T phases
   localparam logic [1:0] T_PER_INSTR_LAST = 2'h3;  // Last T phase of an instruction
   localparam logic [2:0] ENTRY_PULSE_T    = 3'h3;  // Low time on entering debug mode
   localparam logic [2:0] READY_PULSE_T    = 3'h4;  // Low time when read data is ready
   localparam logic [2:0] PULSE_ONE        = 3'h1;  // Unit step of the pulse counter

   // Serial word lengths
   localparam int         WORD_W          = 16;     // Data word width
   localparam logic [4:0] CMD_LAST_BIT    = 5'h07;  // Count of last command bit
   localparam logic [4:0] WORD_LAST_BIT   = 5'h0f;  // Count of last data bit
   localparam logic [4:0] BIT_ONE         = 5'h01;  // Unit step of the bit counter

   // Command byte layout
   localparam int         CMD_READ_POS    = 7;      // Set: read selected register
   localparam int         CMD_GO_POS      = 6;      // Set: leave debug mode
   localparam int         CMD_SEL_MSB     = 3;      // Register select field top bit
   localparam int         SEL_W           = 4;      // Register select width

   // Synchroniser reset level: request high, clock high, data high
   localparam logic [2:0] SYNC_RST        = 3'h7;
   localparam int         SYNC_RXD        = 0;      // Serial data bit
   localparam int         SYNC_SCLK       = 1;      // Serial clock bit
   localparam int         SYNC_REQ        = 2;      // Debug request bit

   // Port states, one-hot
   typedef enum logic [7:0] {
      ST_RUN    = 8'h01,  // Normal execution, pins show chip status
      ST_ENTRY  = 8'h02,  // Entry pulse on serial output
      ST_CMD    = 8'h04,  // Shifting in a command byte
      ST_DECODE = 8'h08,  // Acting on the command byte
      ST_FETCH  = 8'h10,  // Capturing selected register
      ST_READY  = 8'h20,  // Data ready pulse on serial output
      ST_SEND   = 8'h40,  // Shifting out a data word
      ST_RXDATA = 8'h80   // Shifting in a data word for a write
   } dbp_state_t;

endpackage

/* dbp_sync.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dbp_sync (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic [2:0] pinIn,
   output logic      [2:0] pinSync
);
   // Both stages held in one state record
   typedef struct packed {
      logic [2:0] meta;  // First stage, read only by the second
      logic [2:0] sync;  // Second stage, safe to use
   } dbp_sync_t;

   dbp_sync_t r;    // Registered state
   dbp_sync_t nxt;  // Next state

   // Next state: shift pins through both stages
   always_comb begin
      nxt      = r;
      nxt.meta = pinIn;
      nxt.sync = r.meta;
   end

   // State register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         r <= {dbp_pkg::SYNC_RST, dbp_pkg::SYNC_RST};
      end else begin
         r <= nxt;
      end
   end

   assign pinSync = r.sync;
endmodule

/* dbp_shift.sv */
// Sixteen-bit MSB-first shift register for the serial port
`timescale 1ns/1ps
module dbp_shift (
   input  wire logic                        sys_clk,
   input  wire logic                        rst,
   input  wire logic                        load,
   input  wire logic [dbp_pkg::WORD_W-1:0]  loadVal,
   input  wire logic                        shiftEn,
   input  wire logic                        bitIn,
   output logic      [dbp_pkg::WORD_W-1:0]  word,
   output logic                             msb
);
   // Shift state
   typedef struct packed {
      logic [dbp_pkg::WORD_W-1:0] word;  // Shifting word
   } dbp_shift_t;

   dbp_shift_t r;    // Registered state
   dbp_shift_t nxt;  // Next state

   // Load wins over shift; bits enter at the bottom so the first is the MSB
   always_comb begin
      nxt = r;
      if (load) begin
         nxt.word = loadVal;
      end else if (shiftEn) begin
         nxt.word = {r.word[dbp_pkg::WORD_W-2:0], bitIn};
      end
   end

   // State register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= nxt;
      end
   end

   assign word = r.word;
   assign msb  = r.word[dbp_pkg::WORD_W-1];

   // Each bit shifted in lands in the LSB on the next cycle
   property p_shift_in_lsb;
      @(posedge sys_clk) disable iff (rst)
      (shiftEn && !load) |=> (word[0] == $past(bitIn));
   endproperty
   a_shift_in_lsb: assert property (p_shift_in_lsb) else $error("shift bit lost");
endmodule

/* dbp_port.sv */
// Debug serial port: debug entry, command shifting, read and write of debug registers
`timescale 1ns/1ps
module dbp_port (
   input  wire logic                        sys_clk,
   input  wire logic                        rst,
   input  wire logic                        dbgSerialInStatus0In,
   output logic                             dbgSerialInStatus0Out,
   output logic                             dbgSerialInStatus0Oe_n,
   input  wire logic                        dbgSerialClockStatus1In,
   output logic                             dbgSerialClockStatus1Out,
   output logic                             dbgSerialClockStatus1Oe_n,
   output logic                             dbgSerialOut,
   input  wire logic                        dbgRequest_n,
   input  wire logic                        swDebugReq,
   input  wire logic                        hwBreakReq,
   input  wire logic                        traceStepReq,
   input  wire logic                        statusOutEn,
   input  wire logic [1:0]                  chipStatus,
   input  wire logic [dbp_pkg::WORD_W-1:0]  regRdData,
   output logic      [dbp_pkg::SEL_W-1:0]   regSel,
   output logic      [dbp_pkg::WORD_W-1:0]  regWrData,
   output logic                             regWrStrobe,
   output logic                             debugMode,
   output logic      [1:0]                  tPhase
);
   // Whole state of the port
   typedef struct packed {
      dbp_pkg::dbp_state_t         st;        // Port state
      logic [1:0]                  phase;     // T phase within instruction
      logic                        pend;      // Debug entry requested
      logic [2:0]                  tCnt;      // Pulse length counter
      logic [4:0]                  bitCnt;    // Bits seen in current word
      logic                        sclkPrev;  // Previous synchronised clock level
      logic [dbp_pkg::SEL_W-1:0]   sel;       // Selected debug register
      logic [dbp_pkg::WORD_W-1:0]  wrData;    // Write data to core
      logic                        wrStb;     // Write strobe to core
      logic                        txd;       // Serial output level
      logic                        statOe_n;  // Status pin enable, low drives
      logic [1:0]                  stat;      // Status pin levels
      logic                        dm;        // Debug mode flag
   } dbp_port_t;

   dbp_port_t r;    // Registered state
   dbp_port_t nxt;  // Next state

   logic [2:0]                 pinSync;   // Synchronised pins
   logic                       rxdS;      // Synchronised serial data
   logic                       sclkS;     // Synchronised serial clock
   logic                       reqS_n;    // Synchronised debug request
   logic                       clkFall;   // Serial clock falling edge
   logic                       clkRise;   // Serial clock rising edge
   logic                       shLoad;    // Shifter load
   logic                       shEn;      // Shifter shift
   logic                       shBit;     // Shifter input bit
   logic [dbp_pkg::WORD_W-1:0] shWord;    // Shifter contents
   logic                       shMsb;     // Shifter top bit
   logic                       entryReq;  // Any entry source this cycle

   // Pin inputs cross into the core clock before any use
   dbp_sync u_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pinIn   ({dbgRequest_n, dbgSerialClockStatus1In, dbgSerialInStatus0In}),
      .pinSync (pinSync)
   );

   assign rxdS   = pinSync[dbp_pkg::SYNC_RXD];
   assign sclkS  = pinSync[dbp_pkg::SYNC_SCLK];
   assign reqS_n = pinSync[dbp_pkg::SYNC_REQ];

   // Edges of the host clock, seen only on synchronised levels
   assign clkFall = r.sclkPrev && !sclkS;
   assign clkRise = !r.sclkPrev && sclkS;

   // Shared word shifter for commands, write data and read data
   dbp_shift u_shift (
      .sys_clk (sys_clk),
      .rst     (rst),
      .load    (shLoad),
      .loadVal (regRdData),
      .shiftEn (shEn),
      .bitIn   (shBit),
      .word    (shWord),
      .msb     (shMsb)
   );

   // Entry sources: pin request or core events
   assign entryReq = !reqS_n || swDebugReq || hwBreakReq || traceStepReq;

   // Shifter control: receive on fall only in debug receive states, send on rise
   always_comb begin
      shLoad = (r.st == dbp_pkg::ST_FETCH);
      shEn   = 1'b0;
      shBit  = 1'b0;
      if (clkFall && (r.st == dbp_pkg::ST_CMD || r.st == dbp_pkg::ST_RXDATA)) begin
         shEn  = 1'b1;
         shBit = rxdS;
      end else if (clkRise && r.st == dbp_pkg::ST_SEND && r.bitCnt != '0) begin
         shEn  = 1'b1;
      end
   end

   // Next state of the port
   always_comb begin
      nxt          = r;
      nxt.phase    = r.phase + 2'h1;
      nxt.sclkPrev = sclkS;
      nxt.wrStb    = 1'b0;
      // Status pins driven only outside debug mode
      nxt.statOe_n = r.dm || !statusOutEn;
      nxt.stat     = chipStatus;
      unique case (r.st)
         // Running: latch requests, enter at the instruction boundary
         dbp_pkg::ST_RUN: begin
            nxt.txd  = 1'b1;
            nxt.pend = r.pend || entryReq;
            if ((r.pend || entryReq) && r.phase == dbp_pkg::T_PER_INSTR_LAST) begin
               nxt.st       = dbp_pkg::ST_ENTRY;
               nxt.pend     = 1'b0;
               nxt.dm       = 1'b1;
               nxt.statOe_n = 1'b1;
               nxt.txd      = 1'b0;
               nxt.tCnt     = dbp_pkg::ENTRY_PULSE_T - dbp_pkg::PULSE_ONE;
            end
         end
         // Entry pulse, then wait for a command
         dbp_pkg::ST_ENTRY: begin
            if (r.tCnt == '0) begin
               nxt.st     = dbp_pkg::ST_CMD;
               nxt.txd    = 1'b1;
               nxt.bitCnt = '0;
            end else begin
               nxt.tCnt = r.tCnt - dbp_pkg::PULSE_ONE;
            end
         end
         // Command byte shifting in
         dbp_pkg::ST_CMD: begin
            nxt.txd = 1'b1;
            if (clkFall) begin
               if (r.bitCnt == dbp_pkg::CMD_LAST_BIT) begin
                  nxt.st     = dbp_pkg::ST_DECODE;
                  nxt.bitCnt = '0;
               end else begin
                  nxt.bitCnt = r.bitCnt + dbp_pkg::BIT_ONE;
               end
            end
         end
         // Command decode: leave, read or write
         dbp_pkg::ST_DECODE: begin
            nxt.sel = shWord[dbp_pkg::CMD_SEL_MSB:0];
            if (shWord[dbp_pkg::CMD_GO_POS]) begin
               nxt.st = dbp_pkg::ST_RUN;
               nxt.dm = 1'b0;
            end else if (shWord[dbp_pkg::CMD_READ_POS]) begin
               nxt.st = dbp_pkg::ST_FETCH;
            end else begin
               nxt.st = dbp_pkg::ST_RXDATA;
            end
         end
         // Register contents load into the shifter, then ready pulse
         dbp_pkg::ST_FETCH: begin
            nxt.st   = dbp_pkg::ST_READY;
            nxt.txd  = 1'b0;
            nxt.tCnt = dbp_pkg::READY_PULSE_T - dbp_pkg::PULSE_ONE;
         end
         // Ready pulse, then present the MSB
         dbp_pkg::ST_READY: begin
            if (r.tCnt == '0) begin
               nxt.st     = dbp_pkg::ST_SEND;
               nxt.txd    = shMsb;
               nxt.bitCnt = '0;
            end else begin
               nxt.tCnt = r.tCnt - dbp_pkg::PULSE_ONE;
            end
         end
         // Data word out, one bit per host clock
         dbp_pkg::ST_SEND: begin
            nxt.txd = shMsb;
            if (clkFall) begin
               if (r.bitCnt == dbp_pkg::WORD_LAST_BIT) begin
                  nxt.st     = dbp_pkg::ST_CMD;
                  nxt.txd    = 1'b1;
                  nxt.bitCnt = '0;
               end else begin
                  nxt.bitCnt = r.bitCnt + dbp_pkg::BIT_ONE;
               end
            end
         end
         // Write data word in, then strobe it to the core
         dbp_pkg::ST_RXDATA: begin
            nxt.txd = 1'b1;
            if (clkFall) begin
               if (r.bitCnt == dbp_pkg::WORD_LAST_BIT) begin
                  nxt.st     = dbp_pkg::ST_CMD;
                  nxt.bitCnt = '0;
                  nxt.wrStb  = 1'b1;
                  nxt.wrData = {shWord[dbp_pkg::WORD_W-2:0], rxdS};
               end else begin
                  nxt.bitCnt = r.bitCnt + dbp_pkg::BIT_ONE;
               end
            end
         end
         // Illegal code: return to running
         default: begin
            nxt.st = dbp_pkg::ST_RUN;
            nxt.dm = 1'b0;
         end
      endcase
   end

   // State register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         r          <= '0;
         r.st       <= dbp_pkg::ST_RUN;
         r.txd      <= 1'b1;
         r.statOe_n <= 1'b1;
         r.sclkPrev <= 1'b1;
      end else begin
         r <= nxt;
      end
   end

   // Outputs straight from state flops
   assign dbgSerialOut              = r.txd;
   assign dbgSerialInStatus0Out     = r.stat[0];
   assign dbgSerialClockStatus1Out  = r.stat[1];
   assign dbgSerialInStatus0Oe_n    = r.statOe_n;
   assign dbgSerialClockStatus1Oe_n = r.statOe_n;
   assign regSel                    = r.sel;
   assign regWrData                 = r.wrData;
   assign regWrStrobe               = r.wrStb;
   assign debugMode                 = r.dm;
   assign tPhase                    = r.phase;

   // Checks on the port behaviour
   sequence s_low3;
      !dbgSerialOut [*3] ##1 dbgSerialOut;
   endsequence

   sequence s_low4;
      !dbgSerialOut [*4];
   endsequence

   property p_ignore_outside;
      @(posedge sys_clk) disable iff (rst)
      !r.dm |-> !shEn;
   endproperty
   a_ignore_outside: assert property (p_ignore_outside) else $error("input used outside debug");

   property p_sample_fall;
      @(posedge sys_clk) disable iff (rst)
      (shEn && r.st != dbp_pkg::ST_SEND) |-> ($past(sclkS) && !sclkS);
   endproperty
   a_sample_fall: assert property (p_sample_fall) else $error("sample not on fall");

   property p_status_out;
      @(posedge sys_clk) disable iff (rst)
      (!r.dm && statusOutEn) ##1 !r.dm |-> (!dbgSerialInStatus0Oe_n
         && {dbgSerialClockStatus1Out, dbgSerialInStatus0Out} == $past(chipStatus));
   endproperty
   a_status_out: assert property (p_status_out) else $error("status pins wrong");

   property p_idle_high;
      @(posedge sys_clk) disable iff (rst)
      (r.st == dbp_pkg::ST_CMD || r.st == dbp_pkg::ST_RXDATA) |-> dbgSerialOut;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("output not high at idle");

   property p_fetch_load;
      @(posedge sys_clk) disable iff (rst)
      (r.st == dbp_pkg::ST_FETCH) |=> (shWord == $past(regRdData) && regSel == $past(regSel));
   endproperty
   a_fetch_load: assert property (p_fetch_load) else $error("wrong register loaded");

   property p_ready_pulse;
      @(posedge sys_clk) disable iff (rst)
      (r.st == dbp_pkg::ST_FETCH) |=> s_low4 ##1 (r.st == dbp_pkg::ST_SEND);
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready pulse not four T");

   property p_entry_pulse;
      @(posedge sys_clk) disable iff (rst)
      $rose(debugMode) |-> s_low3;
   endproperty
   a_entry_pulse: assert property (p_entry_pulse) else $error("entry pulse not three T");

   property p_send_msb;
      @(posedge sys_clk) disable iff (rst)
      (r.st == dbp_pkg::ST_SEND && nxt.st == dbp_pkg::ST_SEND) |=> dbgSerialOut == $past(shMsb);
   endproperty
   a_send_msb: assert property (p_send_msb) else $error("output not MSB");

   property p_entry_boundary;
      @(posedge sys_clk) disable iff (rst)
      $rose(debugMode) |-> ($past(tPhase) == dbp_pkg::T_PER_INSTR_LAST);
   endproperty
   a_entry_boundary: assert property (p_entry_boundary) else $error("entry mid instruction");

   property p_phase_step;
      @(posedge sys_clk) disable iff (rst)
      (tPhase == dbp_pkg::T_PER_INSTR_LAST) |=> (tPhase == 2'h0);
   endproperty
   a_phase_step: assert property (p_phase_step) else $error("phase count wrong");
endmodule

/* dbp_host_model.sv */
// Behavioural debug host that clocks words over the serial debug link
`timescale 1ns/1ps
module dbp_host_model (
   input  wire logic sys_clk,
   input  wire logic serialOut,
   output logic      hostClk,
   output logic      hostData
);
   // Host clock half period in sys_clk cycles; the shortest the port allows, so the
   // last command rise lands before the ready pulse and waitReady sees all of it
   localparam int HALF = 4;

   // Clock idles high between frames, data line starts high
   initial begin
      hostClk  = 1'b1;
      hostData = 1'b1;
   end

   // One bit: data changes while the clock is high, then a fall and a rise
   task automatic bitCycle(input logic din, output logic dout);
      hostData = din;
      repeat (HALF) @(posedge sys_clk);
      #1;
      dout = serialOut;
      hostClk = 1'b0;
      repeat (HALF) @(posedge sys_clk);
      #1;
      hostClk = 1'b1;
   endtask

   // Released data line shows the inverse of the last bit, not a stale copy
   task automatic releaseData();
      hostData = ~hostData;
   endtask

   // Command byte, top bit first
   task automatic shiftCmd(input logic [7:0] cmd);
      logic d;
      for (int i = 7; i >= 0; i--) begin
         bitCycle(cmd[i], d);
      end
      releaseData();
   endtask

   // Data word for a register write, top bit first
   task automatic shiftWord(input logic [15:0] w);
      logic d;
      for (int i = 15; i >= 0; i--) begin
         bitCycle(w[i], d);
      end
      releaseData();
   endtask

   // Waits for a low pulse on the serial output and measures its length
   task automatic waitReady(output int lowCnt);
      int n;
      lowCnt = 0;
      n = 0;
      while (serialOut !== 1'b0 && n < 200) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      while (serialOut === 1'b0 && lowCnt < 20) begin
         @(posedge sys_clk);
         #1;
         lowCnt++;
      end
   endtask

   // Clocks a read word out without waiting for the ready pulse, top bit first
   task automatic readWord(output logic [15:0] w);
      for (int i = 15; i >= 0; i--) begin
         bitCycle(~hostData, w[i]);
      end
      releaseData();
   endtask
endmodule

/* test_debug_serial_port.sv */
// Self-checking testbench for the debug serial port
`timescale 1ns/1ps
module test_debug_serial_port;
   logic        sysClk = 1'b0;        // Core clock
   logic        rst = 1'b1;           // Asynchronous reset
   logic        dbgRequest_n = 1'b1;  // External debug request pin
   logic        swDebugReq = 1'b0;    // Software debug instruction
   logic        hwBreakReq = 1'b0;    // Hardware breakpoint
   logic        traceStepReq = 1'b0;  // Trace or step
   logic        statusOutEn = 1'b0;   // Status pins enabled
   logic [1:0]  chipStatus = 2'h0;    // Status code for the pins
   logic [15:0] regRdData;            // Core register read value
   logic [3:0]  regSel;               // Selected register
   logic [15:0] regWrData;            // Write data
   logic        regWrStrobe;          // Write pulse
   logic        debugMode;            // Core halted
   logic [1:0]  tPhase;               // T phase count
   logic        stat0Out;             // Status bit 0 driven by the device
   logic        stat0Oe_n;            // Status bit 0 drive enable
   logic        stat1Out;             // Status bit 1 driven by the device
   logic        stat1Oe_n;            // Status bit 1 drive enable
   logic        serOut;               // Serial output of the device
   logic        hostClk;              // Host serial clock
   logic        hostData;             // Host serial data
   wire logic   dataPin;              // Resolved data pin level
   wire logic   clkPin;               // Resolved clock pin level
   int          fails = 0;            // Mismatches
   int          samplesChecked = 0;   // Comparisons made
   int          wrCount = 0;          // Write pulses seen
   int          lowCycles = 0;        // Cycles with serial output low
   logic [15:0] wrData;               // Last written value
   logic [3:0]  wrSel;                // Register of last write

   // Core register contents seen through the select
   function automatic logic [15:0] rdVal(input logic [3:0] s);
      // Top bit kept high so the end of the ready pulse shows on the line
      return 16'h8000 | (16'h5a30 ^ {s, s, s, s});
   endfunction

   assign regRdData = rdVal(regSel);
   // Device drives a pin while its enable is low, host otherwise
   assign dataPin = (stat0Oe_n === 1'b0) ? stat0Out : hostData;
   assign clkPin  = (stat1Oe_n === 1'b0) ? stat1Out : hostClk;

   // Clock of 10 ns
   always #5 sysClk = ~sysClk;

   // Records write pulses and low output cycles
   always @(posedge sysClk) begin
      if (regWrStrobe === 1'b1) begin
         wrCount++;
         wrData = regWrData;
         wrSel = regSel;
      end
      if (serOut === 1'b0) begin
         lowCycles++;
      end
   end

   dbp_port u_dut (
      .sys_clk(sysClk), .rst(rst),
      .dbgSerialInStatus0In(dataPin), .dbgSerialInStatus0Out(stat0Out),
      .dbgSerialInStatus0Oe_n(stat0Oe_n), .dbgSerialClockStatus1In(clkPin),
      .dbgSerialClockStatus1Out(stat1Out), .dbgSerialClockStatus1Oe_n(stat1Oe_n),
      .dbgSerialOut(serOut), .dbgRequest_n(dbgRequest_n), .swDebugReq(swDebugReq),
      .hwBreakReq(hwBreakReq), .traceStepReq(traceStepReq), .statusOutEn(statusOutEn),
      .chipStatus(chipStatus), .regRdData(regRdData), .regSel(regSel),
      .regWrData(regWrData), .regWrStrobe(regWrStrobe), .debugMode(debugMode),
      .tPhase(tPhase)
   );

   dbp_host_model u_host (
      .sys_clk(sysClk), .serialOut(serOut), .hostClk(hostClk), .hostData(hostData)
   );

   // Compares one value and reports a mismatch
   task automatic checkVal(input logic [15:0] got, input logic [15:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Lets n edges pass, then steps off the edge
   task automatic tickN(input int n);
      repeat (n) @(posedge sysClk);
      #1;
   endtask

   // Reset held for 20 cycles, idle values checked during it
   task automatic doReset();
      rst = 1'b1;
      tickN(20);
      checkVal({15'h0, serOut}, 16'h1);
      checkVal({14'h0, stat0Oe_n, stat1Oe_n}, 16'h3);
      checkVal({14'h0, debugMode, regWrStrobe}, 16'h0);
      rst = 1'b0;
   endtask

   // Every status code on the two shared pins outside debug mode
   task automatic testStatus();
      statusOutEn = 1'b1;
      for (int s = 0; s < 4; s++) begin
         chipStatus = 2'(s);
         tickN(3);
         checkVal({14'h0, stat1Out, stat0Out}, 16'(s));
         checkVal({14'h0, stat0Oe_n, stat1Oe_n}, 16'h0);
      end
      statusOutEn = 1'b0;
      tickN(3);
      checkVal({14'h0, stat0Oe_n, stat1Oe_n}, 16'h3);
   endtask

   // A read command outside debug mode must be ignored
   task automatic testIgnore();
      int low0;
      low0 = lowCycles;
      u_host.shiftCmd(8'h85);
      tickN(20);
      checkVal({15'h0, debugMode}, 16'h0);
      checkVal(16'(lowCycles - low0), 16'h0);
   endtask

   // Enters debug mode from one source and checks the entry pulse
   task automatic enterDebug(input int src);
      int n;
      n = 0;
      dbgRequest_n = (src != 0);
      swDebugReq = (src == 1);
      hwBreakReq = (src == 2);
      traceStepReq = (src == 3);
      tickN(1);
      swDebugReq = 1'b0;
      hwBreakReq = 1'b0;
      traceStepReq = 1'b0;
      while (debugMode !== 1'b1 && n < 30) begin
         tickN(1);
         n++;
      end
      dbgRequest_n = 1'b1;
      checkVal({15'h0, debugMode}, 16'h1);
      checkVal({14'h0, tPhase}, 16'h0);
      u_host.waitReady(n);
      checkVal(16'(n), 16'h3);
   endtask

   // Read command: ready pulse, then the selected register MSB first
   task automatic testRead(input logic [3:0] sel);
      int n;
      logic [15:0] w;
      u_host.shiftCmd({4'h8, sel});
      u_host.waitReady(n);
      checkVal(16'(n), 16'h4);
      checkVal({12'h0, regSel}, {12'h0, sel});
      u_host.readWord(w);
      checkVal(w, rdVal(sel));
      tickN(4);
      checkVal({15'h0, serOut}, 16'h1);
   endtask

   // Write command: word arrives MSB first with one strobe
   task automatic testWrite(input logic [3:0] sel, input logic [15:0] data);
      int c0;
      c0 = wrCount;
      u_host.shiftCmd({4'h0, sel});
      // Lets the released data level stand before the first data bit is set
      tickN(2);
      u_host.shiftWord(data);
      tickN(10);
      checkVal(16'(wrCount - c0), 16'h1);
      checkVal(wrData, data);
      checkVal({12'h0, wrSel}, {12'h0, sel});
   endtask

   // Leave command with the read bit also set: no data pulse expected
   task automatic exitDebug();
      int low0;
      low0 = lowCycles;
      u_host.shiftCmd(8'hc0);
      tickN(20);
      checkVal({15'h0, debugMode}, 16'h0);
      checkVal(16'(lowCycles - low0), 16'h0);
   endtask

   // Prints counts and verdict, ends the run
   task automatic results();
      $display("Summary: checks=%0d mismatches=%0d", samplesChecked, fails);
      if (fails == 0 && samplesChecked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      doReset();
      testStatus();
      testIgnore();
      for (int src = 0; src < 4; src++) begin
         enterDebug(src);
         case (src)
            0: begin
               testRead(4'h0);
               testWrite(4'hf, 16'h9c3a);
            end
            1: begin
               testRead(4'hf);
               testRead(4'h5);
            end
            2: testWrite(4'h0, 16'h8001);
            default: testRead(4'ha);
         endcase
         exitDebug();
      end
      results();
   end

   // Watchdog well beyond the expected run length
   initial begin
      #400000;
      fails++;
      $display("Watchdog expired at t=%0t", $time);
      results();
   end
endmodule
